// File: src/cpu8_opcode_decoder.sv
// one-byte opcode decoder with operand address arithmetic and the
// status register that sits in the register file
// assumes opcode bytes arrive from program memory on sys_clk
`timescale 1ns/1ns
module cpu8_opcode_decoder
  import cpu8_decode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  input wire logic [7:0] base_reg,
  input wire logic [7:0] wreg_data,
  input wire logic [3:0] pair_sel,
  input wire logic [7:0] pair_addr,
  input wire logic [15:0] pair_ptr,
  input wire logic [7:0] disp_short,
  input wire logic [LONG_OFS_W-1:0] disp_long,
  input wire logic [15:0] direct_addr,
  input wire logic [15:0] next_pc,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic alu_flag_wr,
  input wire logic [7:0] alu_flags,
  output logic dec_valid_q,
  output op_t op_q,
  output mode_t dst_mode_q,
  output mode_t src_mode_q,
  output logic [3:0] nib_q,
  output logic cond_true_q,
  output logic unimpl_q,
  output logic [7:0] index_addr_q,
  output logic [15:0] short_ea_q,
  output logic [15:0] long_ea_q,
  output logic [15:0] rel_target_q,
  output logic direct_ok_q,
  output logic wpair_ok_q,
  output logic rpair_ok_q,
  output logic status_hit_q,
  output logic [7:0] reg_rdata_q,
  output logic [7:0] cpu_status_flags_q
);

  // ==========================================================
  // helpers

  // pairs start on an even address, bit 0 must be clear
  function automatic logic even_ok(input logic [7:0] a);
    even_ok = ~a[0];
  endfunction

  // condition field against carry, zero, sign, overflow
  function automatic logic cond_eval(input logic [3:0] cf, input logic [7:0] st);
    logic c;
    logic z;
    logic s;
    logic v;
    logic t;
    c = st[CARRY_BIT];
    z = st[ZERO_BIT];
    s = st[SIGN_BIT];
    v = st[OVF_BIT];
    unique case (cf[2:0])
      3'h0: t = 1'b0; // never, inverted gives always
      3'h1: t = s ^ v; // less than
      3'h2: t = z | (s ^ v); // less or equal
      3'h3: t = c | z; // unsigned less or equal
      3'h4: t = v; // overflow
      3'h5: t = s; // minus
      3'h6: t = z; // zero
      3'h7: t = c; // carry
    endcase
    cond_eval = cf[3] ? ~t : t; // upper half is the negation
  endfunction

  // ==========================================================
  // opcode decode
  logic [3:0] hi; // row of the map
  logic [3:0] lo; // column of the map
  op_t op_d; // decoded class
  mode_t dst_d; // destination form
  mode_t src_d; // source form
  logic unimpl_d; // empty map slot

  assign hi = op_byte[7:4];
  assign lo = op_byte[3:0];

  // one flat case over the columns, rows inside
  always_comb begin
    op_d = OP_NOP;
    dst_d = MD_NONE;
    src_d = MD_NONE;
    unimpl_d = 1'b0;
    unique case (lo)
      4'hF: begin
        unique case (hi)
          4'h6: op_d = OP_ENTER_IDLE;
          4'h7: op_d = OP_ENTER_STOP;
          4'h8: op_d = OP_INT_DISABLE;
          4'h9: op_d = OP_INT_ENABLE;
          4'hA: op_d = OP_RETURN;
          4'hB: op_d = OP_INT_RETURN;
          4'hC: op_d = OP_CARRY_CLEAR;
          4'hD: op_d = OP_CARRY_SET;
          4'hE: op_d = OP_CARRY_COMPL;
          4'hF: op_d = OP_NOP;
          default: unimpl_d = 1'b1;
        endcase
      end
      // row nibble is the register or condition, no extra byte
      4'h8: begin
        op_d = OP_LOAD;
        dst_d = MD_WREG;
        src_d = MD_REG;
      end
      4'h9: begin
        op_d = OP_STORE_WREG;
        dst_d = MD_REG;
        src_d = MD_WREG;
      end
      4'hB: begin
        op_d = OP_REL_JUMP;
        src_d = MD_RELATIVE;
      end
      4'hC: begin
        op_d = OP_LOAD;
        dst_d = MD_WREG;
        src_d = MD_CONST;
      end
      4'hD: begin
        op_d = OP_ABS_JUMP;
        src_d = MD_DIRECT;
      end
      4'hE: begin
        op_d = OP_INCREMENT;
        dst_d = MD_WREG;
      end
      4'hA: unimpl_d = 1'b1;
      4'h0, 4'h1: begin
        dst_d = lo[0] ? MD_IND_REG : MD_REG;
        unique case (hi)
          4'h0: op_d = OP_DECREMENT;
          4'h1: op_d = OP_ROT_LEFT_CARRY;
          4'h2: op_d = OP_INCREMENT;
          4'h3: begin
            // only 30 is the indirect pair jump
            op_d = OP_ABS_JUMP;
            dst_d = MD_NONE;
            src_d = MD_PAIR_IND;
            unimpl_d = lo[0];
          end
          4'h5: op_d = OP_POP;
          4'h6: op_d = OP_COMPLEMENT;
          4'h7: op_d = OP_PUSH;
          4'h9: op_d = OP_ROT_LEFT;
          4'hB: op_d = OP_CLEAR;
          4'hC: op_d = OP_ROT_RIGHT_CARRY;
          4'hD: op_d = OP_SHIFT_RIGHT_ARITH;
          4'hE: op_d = OP_ROT_RIGHT;
          default: begin
            dst_d = MD_NONE;
            unimpl_d = 1'b1;
          end
        endcase
        if (unimpl_d) begin
          op_d = OP_NOP;
          src_d = MD_NONE;
        end
      end
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
        if (hi <= 4'h7 || hi == 4'hA || hi == 4'hB) begin
          // operand forms by column
          unique case (lo)
            4'h2: begin dst_d = MD_WREG; src_d = MD_WREG; end
            4'h3: begin dst_d = MD_WREG; src_d = MD_IND_WREG; end
            4'h4: begin dst_d = MD_REG; src_d = MD_REG; end
            4'h5: begin dst_d = MD_REG; src_d = MD_IND_REG; end
            default: begin dst_d = MD_REG; src_d = MD_CONST; end
          endcase
          unique case (hi)
            4'h0: op_d = OP_ADD;
            4'h1: op_d = OP_ADD_CARRY;
            4'h2: op_d = OP_SUBTRACT;
            4'h3: op_d = OP_SUB_CARRY;
            4'h4: op_d = OP_OR;
            4'h5: op_d = OP_AND;
            4'h6: op_d = OP_TEST_COMPL_MASK;
            4'h7: op_d = OP_TEST_MASK;
            4'hA: op_d = OP_COMPARE;
            default: op_d = OP_XOR;
          endcase
        end else begin
          unique case (op_byte)
            8'hC3: begin op_d = OP_PGM_LOAD; dst_d = MD_WREG; src_d = MD_WPAIR_IND; end
            8'hD3: begin op_d = OP_PGM_STORE; dst_d = MD_WPAIR_IND; src_d = MD_WREG; end
            8'hD6: begin op_d = OP_LOAD; dst_d = MD_IND_REG; src_d = MD_CONST; end
            8'hE2: begin op_d = OP_PGM_LOAD_DEC; dst_d = MD_WREG; src_d = MD_WPAIR_IND; end
            8'hE3: begin op_d = OP_PGM_LOAD_INC; dst_d = MD_WREG; src_d = MD_WPAIR_IND; end
            8'hE4: begin op_d = OP_LOAD; dst_d = MD_REG; src_d = MD_REG; end
            8'hE5: begin op_d = OP_LOAD; dst_d = MD_REG; src_d = MD_IND_REG; end
            8'hE6: begin op_d = OP_LOAD; dst_d = MD_REG; src_d = MD_CONST; end
            8'hF4: begin op_d = OP_CALL; src_d = MD_PAIR_IND; end
            8'hF5: begin op_d = OP_LOAD; dst_d = MD_IND_REG; src_d = MD_REG; end
            8'hF6: begin op_d = OP_CALL; src_d = MD_DIRECT; end
            default: unimpl_d = 1'b1;
          endcase
        end
      end
      default: begin
        // column 7, rows 8..F only
        if (hi >= NIB_FIRST_INDEX) begin
          unique case (hi[2:0])
            3'h0: begin op_d = OP_LOAD; dst_d = MD_WREG; src_d = MD_INDEXED; end
            3'h1: begin op_d = OP_STORE_WREG; dst_d = MD_INDEXED; src_d = MD_WREG; end
            3'h2: begin op_d = OP_PGM_LOAD; dst_d = MD_WREG; src_d = MD_LONG_OFS; end
            3'h3: begin op_d = OP_PGM_STORE; dst_d = MD_LONG_OFS; src_d = MD_WREG; end
            3'h4: begin op_d = OP_LOAD; dst_d = MD_WREG; src_d = MD_IND_WREG; end
            3'h5: begin op_d = OP_LOAD; dst_d = MD_IND_WREG; src_d = MD_WREG; end
            3'h6: begin op_d = OP_PGM_LOAD; dst_d = MD_WREG; src_d = MD_SHORT_OFS; end
            3'h7: begin op_d = OP_PGM_STORE; dst_d = MD_SHORT_OFS; src_d = MD_WREG; end
          endcase
        end else begin
          unimpl_d = 1'b1;
        end
      end
    endcase
  end

  // ==========================================================
  // decode outputs and operand address arithmetic
  logic dec_valid_d;
  logic cond_true_d;
  logic [7:0] index_addr_d;
  logic [15:0] short_ea_d;
  logic [15:0] long_ea_d;
  logic [15:0] rel_target_d;

  // plain sums; the core only reads them for the matching form
  always_comb begin
    dec_valid_d = op_valid;
    cond_true_d = cond_eval(hi, cpu_status_flags_q);
    index_addr_d = base_reg + wreg_data;
    short_ea_d = pair_ptr + {{8{disp_short[7]}}, disp_short};
    long_ea_d = pair_ptr + {3'h0, disp_long};
    rel_target_d = next_pc + {{8{disp_short[7]}}, disp_short};
  end

  // decode fields hold until the next valid byte; valid, the address sums and the range checks update every cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_valid_q <= 1'b0;
      op_q <= OP_NOP;
      dst_mode_q <= MD_NONE;
      src_mode_q <= MD_NONE;
      nib_q <= 4'h0;
      cond_true_q <= 1'b0;
      unimpl_q <= 1'b0;
      index_addr_q <= 8'h00;
      short_ea_q <= 16'h0000;
      long_ea_q <= 16'h0000;
      rel_target_q <= 16'h0000;
      direct_ok_q <= 1'b0;
      wpair_ok_q <= 1'b0;
      rpair_ok_q <= 1'b0;
    end else begin
      dec_valid_q <= dec_valid_d;
      if (op_valid) begin
        op_q <= op_d;
        dst_mode_q <= dst_d;
        src_mode_q <= src_d;
        nib_q <= hi;
        cond_true_q <= cond_true_d;
        unimpl_q <= unimpl_d;
      end
      index_addr_q <= index_addr_d;
      short_ea_q <= short_ea_d;
      long_ea_q <= long_ea_d;
      rel_target_q <= rel_target_d;
      direct_ok_q <= (direct_addr <= DIRECT_LIMIT);
      wpair_ok_q <= even_ok({4'h0, pair_sel});
      rpair_ok_q <= even_ok(pair_addr);
    end
  end

  // ==========================================================
  // status register in the register file
  logic [7:0] status_d;
  logic status_hit_d;
  logic [7:0] reg_rdata_d;

  // software write wins over the carry ops and the alu update; a
  // clash has no useful outcome, so one fixed winner is enough
  always_comb begin
    status_d = cpu_status_flags_q;
    if (alu_flag_wr) begin
      status_d = alu_flags;
    end
    if (op_valid && op_d == OP_CARRY_CLEAR) begin
      status_d[CARRY_BIT] = 1'b0;
    end
    if (op_valid && op_d == OP_CARRY_SET) begin
      status_d[CARRY_BIT] = 1'b1;
    end
    if (op_valid && op_d == OP_CARRY_COMPL) begin
      status_d[CARRY_BIT] = ~cpu_status_flags_q[CARRY_BIT];
    end
    status_hit_d = (reg_addr == STATUS_ADDR);
    if (reg_wr && status_hit_d) begin
      status_d = reg_wdata;
    end
    reg_rdata_d = (reg_rd && status_hit_d) ? cpu_status_flags_q : 8'h00;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_status_flags_q <= STATUS_RESET;
      status_hit_q <= 1'b0;
      reg_rdata_q <= 8'h00;
    end else begin
      cpu_status_flags_q <= status_d;
      status_hit_q <= status_hit_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence carry_op_s(logic [7:0] code);
    op_valid && op_byte == code && !alu_flag_wr && !reg_wr;
  endsequence

  status_write_a: assert property (reg_wr && reg_addr == 8'hD5 |=> cpu_status_flags_q == $past(reg_wdata))
    else $error("status write lost");
  status_read_a: assert property (reg_rd && reg_addr == 8'hD5 |=> reg_rdata_q == $past(cpu_status_flags_q))
    else $error("status read wrong");
  carry_set_a: assert property (carry_op_s(8'hDF) |=> cpu_status_flags_q[CARRY_BIT] && op_q == OP_CARRY_SET)
    else $error("carry set failed");
  ctrl_column_a: assert property (op_valid && op_byte == 8'hBF |=> op_q == OP_INT_RETURN && !unimpl_q)
    else $error("column F decode wrong");
  reg_nibble_a: assert property (op_valid && op_byte[3:0] == 4'hC |=> op_q == OP_LOAD && src_mode_q == MD_CONST
    && nib_q == $past(op_byte[7:4]))
    else $error("register nibble lost");
  alu_group_a: assert property (op_valid && op_byte == 8'hA5 |=> op_q == OP_COMPARE && src_mode_q == MD_IND_REG)
    else $error("alu decode wrong");
  empty_slot_a: assert property (op_valid && op_byte == 8'h31 |=> unimpl_q && op_q == OP_NOP)
    else $error("empty slot not nop");
  index_sum_a: assert property ($past(rst_n) |-> index_addr_q == 8'($past(base_reg) + $past(wreg_data)))
    else $error("indexed address wrong");
  rel_target_a: assert property ($past(rst_n) |-> rel_target_q ==
    16'($past(next_pc) + 16'($signed($past(disp_short)))))
    else $error("relative target wrong");
  always_true_a: assert property (op_valid && op_byte == 8'h8B |=> cond_true_q && op_q == OP_REL_JUMP)
    else $error("always-true condition failed");
  pair_even_a: assert property (pair_addr[0] |=> !rpair_ok_q)
    else $error("odd pair accepted");

endmodule

// File: src/cpu8_decode_pkg.sv
// shared constants and types for the 8-bit core opcode decoder
// assumes one system clock and an asynchronous active-low reset
package cpu8_decode_pkg;

  // ==========================================================
  // status register placement and layout
  localparam logic [7:0] STATUS_ADDR = 8'hD5; // register-file address
  localparam logic [7:0] STATUS_RESET = 8'h00; // value after reset
  localparam int CARRY_BIT = 7; // carry position
  localparam int ZERO_BIT = 6; // zero position
  localparam int SIGN_BIT = 5; // sign position
  localparam int OVF_BIT = 4; // overflow position

  // ==========================================================
  // address range limits
  localparam logic [15:0] DIRECT_LIMIT = 16'h1FFF; // highest direct target
  localparam int LONG_OFS_W = 13; // long displacement width, 0..8191
  localparam logic [3:0] NIB_FIRST_INDEX = 4'h8; // first indexed-load row

  // ==========================================================
  // decoded operation classes
  typedef enum logic [5:0] {
    OP_NOP, OP_ENTER_IDLE, OP_ENTER_STOP, OP_INT_DISABLE, OP_INT_ENABLE,
    OP_RETURN, OP_INT_RETURN, OP_CARRY_CLEAR, OP_CARRY_SET, OP_CARRY_COMPL,
    OP_LOAD, OP_STORE_WREG, OP_REL_JUMP, OP_ABS_JUMP, OP_INCREMENT,
    OP_DECREMENT, OP_ROT_LEFT_CARRY, OP_POP, OP_COMPLEMENT, OP_PUSH,
    OP_ROT_LEFT, OP_CLEAR, OP_ROT_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH,
    OP_ROT_RIGHT, OP_ADD, OP_ADD_CARRY, OP_SUBTRACT, OP_SUB_CARRY, OP_OR,
    OP_AND, OP_TEST_COMPL_MASK, OP_TEST_MASK, OP_COMPARE, OP_XOR,
    OP_PGM_LOAD, OP_PGM_STORE, OP_PGM_LOAD_DEC, OP_PGM_LOAD_INC, OP_CALL
  } op_t;

  // ==========================================================
  // operand addressing forms
  typedef enum logic [3:0] {
    MD_NONE, MD_WREG, MD_REG, MD_IND_WREG, MD_IND_REG, MD_WPAIR_IND,
    MD_PAIR_IND, MD_INDEXED, MD_SHORT_OFS, MD_LONG_OFS, MD_DIRECT,
    MD_RELATIVE, MD_CONST
  } mode_t;

endpackage

// File: tb/cpu8_prog_mem.sv
// program memory model that hands opcode bytes to the decoder
// assumes the bench asks for one location at a time on the falling edge
`timescale 1ns/1ns
module cpu8_prog_mem (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic fetch,
  input wire logic [7:0] fetch_addr,
  output logic op_valid,
  output logic [7:0] op_byte
);
  // ==========================================================
  // image and bus
  logic [7:0] last_q; // byte last handed out
  logic [7:0] last_d; // next value of last_q

  // test image: every location holds its own address, so any opcode is reachable
  always_comb begin
    last_d = fetch ? fetch_addr : last_q;
    op_valid = fetch;
    // released bus shows the inverse, so a stale byte never looks valid
    op_byte = fetch ? fetch_addr : ~last_q;
  end

  // keeps the last byte for the released-bus pattern
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 8'h00;
    end else begin
      last_q <= last_d;
    end
  end
endmodule

// File: tb/cpu8_opcode_decoder_tb.sv
// self-checking bench for the opcode decoder and its status register
// assumes the program memory model feeds opcodes; inputs change on falling edges
`timescale 1ns/1ns
module cpu8_opcode_decoder_tb;
  import cpu8_decode_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic sys_clk = 1'b0, rst_n = 1'b0, fetch = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, alu_flag_wr = 1'b0;
  logic [7:0] fetch_addr = 8'h00, base_reg = 8'h00, wreg_data = 8'h00, pair_addr = 8'h00, disp_short = 8'h00;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, alu_flags = 8'h00, op_byte, index_addr_q, reg_rdata_q;
  logic [3:0] pair_sel = 4'h0, nib_q;
  logic [15:0] pair_ptr = 16'h0000, direct_addr = 16'h0000, next_pc = 16'h0000, short_ea_q, long_ea_q, rel_target_q;
  logic [LONG_OFS_W-1:0] disp_long = '0;
  logic op_valid, dec_valid_q, cond_true_q, unimpl_q, direct_ok_q, wpair_ok_q, rpair_ok_q, status_hit_q;
  logic [7:0] cpu_status_flags_q;
  op_t op_q;
  mode_t dst_mode_q, src_mode_q;
  int fail_count = 0, compares = 0, cyc = 0;
  // opcode table; blank slots expect a no-op
  localparam int N = 51;
  logic [7:0] tb_b [N] = '{8'h00, 8'h10, 8'h20, 8'h50, 8'h60, 8'h70, 8'h90, 8'hB0, 8'hC0, 8'hD0, 8'hE0, 8'h30,
    8'h02, 8'h12, 8'h22, 8'h32, 8'h42, 8'h52, 8'h62, 8'h72, 8'hA6, 8'hB4, 8'h6F, 8'h7F, 8'h8F, 8'h9F, 8'hAF,
    8'hBF, 8'hFF, 8'h08, 8'h19, 8'h2B, 8'h3C, 8'h4D, 8'h5E, 8'hA7, 8'hB7, 8'hF7, 8'hC3, 8'hD3, 8'hE2, 8'hE3,
    8'hE4, 8'hF4, 8'hF6, 8'hF5, 8'h31, 8'h0A, 8'h40, 8'h81, 8'h0F};
  op_t tb_o [N] = '{OP_DECREMENT, OP_ROT_LEFT_CARRY, OP_INCREMENT, OP_POP, OP_COMPLEMENT, OP_PUSH, OP_ROT_LEFT,
    OP_CLEAR, OP_ROT_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH, OP_ROT_RIGHT, OP_ABS_JUMP, OP_ADD, OP_ADD_CARRY,
    OP_SUBTRACT, OP_SUB_CARRY, OP_OR, OP_AND, OP_TEST_COMPL_MASK, OP_TEST_MASK, OP_COMPARE, OP_XOR,
    OP_ENTER_IDLE, OP_ENTER_STOP, OP_INT_DISABLE, OP_INT_ENABLE, OP_RETURN, OP_INT_RETURN, OP_NOP, OP_LOAD,
    OP_STORE_WREG, OP_REL_JUMP, OP_LOAD, OP_ABS_JUMP, OP_INCREMENT, OP_PGM_LOAD, OP_PGM_STORE, OP_PGM_STORE,
    OP_PGM_LOAD, OP_PGM_STORE, OP_PGM_LOAD_DEC, OP_PGM_LOAD_INC, OP_LOAD, OP_CALL, OP_CALL, OP_LOAD, OP_NOP,
    OP_NOP, OP_NOP, OP_NOP, OP_NOP};
  mode_t sm [5] = '{MD_WREG, MD_IND_WREG, MD_REG, MD_IND_REG, MD_CONST}; // source form per column 2..6
  logic [7:0] fl [4] = '{8'hA0, 8'h50, 8'h30, 8'h00}; // flag patterns for the condition sweep

  // ==========================================================
  // design, memory model, clock
  cpu8_prog_mem cpu8_prog_mem_i (.sys_clk, .rst_n, .fetch, .fetch_addr, .op_valid, .op_byte);
  cpu8_opcode_decoder cpu8_opcode_decoder_i (.sys_clk, .rst_n, .op_valid, .op_byte, .base_reg, .wreg_data,
    .pair_sel, .pair_addr, .pair_ptr, .disp_short, .disp_long, .direct_addr, .next_pc, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .alu_flag_wr, .alu_flags, .dec_valid_q, .op_q, .dst_mode_q, .src_mode_q, .nib_q,
    .cond_true_q, .unimpl_q, .index_addr_q, .short_ea_q, .long_ea_q, .rel_target_q, .direct_ok_q, .wpair_ok_q,
    .rpair_ok_q, .status_hit_q, .reg_rdata_q, .cpu_status_flags_q);
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      stop_test();
    end
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string m);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %0t %s: seen %h expected %h", $time, m, s, e);
    end
  endtask
  // one opcode fetch; results are settled at the falling edge where it returns
  task automatic dec(input logic [7:0] b);
    @(negedge sys_clk);
    fetch = 1'b1;
    fetch_addr = b;
    @(negedge sys_clk);
    fetch = 1'b0;
  endtask
  // register access; strobe is one cycle wide
  task automatic reg_acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  // expected condition result: bit 3 turns the sense round
  function automatic logic cexp(input logic [3:0] cf, input logic [7:0] f);
    logic r;
    case (cf[2:0])
      3'h0: r = 1'b0;
      3'h1: r = f[5] ^ f[4];
      3'h2: r = f[6] | (f[5] ^ f[4]);
      3'h3: r = f[7] | f[6];
      3'h4: r = f[4];
      3'h5: r = f[5];
      3'h6: r = f[6];
      default: r = f[7];
    endcase
    return r ^ cf[3];
  endfunction
  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    chk(cpu_status_flags_q, STATUS_RESET, "status after reset");
    chk(op_q, OP_NOP, "op after reset");
    // sweep of the 51-entry opcode table, one idle cycle between fetches
    for (int i = 0; i < N; i++) begin
      dec(tb_b[i]);
      chk(dec_valid_q, 1'b1, "valid");
      chk(op_q, tb_o[i], "op class");
      chk(unimpl_q, tb_o[i] == OP_NOP && tb_b[i] != 8'hFF, "empty slot");
      chk(nib_q, tb_b[i][7:4], "nibble");
    end
    @(negedge sys_clk);
    chk(dec_valid_q, 1'b0, "valid one cycle");
    $display("test opcode map done");
    // operand forms of the two-operand group
    for (int c = 2; c < 7; c++) begin
      dec(8'hA0 | c[7:0]);
      chk(dst_mode_q, c < 4 ? MD_WREG : MD_REG, "dst form");
      chk(src_mode_q, sm[c-2], "src form");
    end
    // indirect single-operand column
    dec(8'hD1);
    chk(op_q, OP_SHIFT_RIGHT_ARITH, "indirect column op");
    chk(dst_mode_q, MD_IND_REG, "indirect column dst");
    $display("test operand forms done");
    // every condition code against four flag patterns
    foreach (fl[k]) begin
      reg_acc(1'b1, STATUS_ADDR, fl[k]);
      for (int cn = 0; cn < 16; cn++) begin
        dec({cn[3:0], 4'hB});
        chk(cond_true_q, cexp(cn[3:0], fl[k]), "condition");
      end
    end
    $display("test conditions done");
    // address arithmetic at its boundaries
    @(negedge sys_clk);
    base_reg = 8'hFF;
    wreg_data = 8'h02;
    pair_ptr = 16'h1000;
    disp_short = 8'h80;
    disp_long = 13'h1FFF;
    next_pc = 16'h0100;
    direct_addr = DIRECT_LIMIT;
    pair_sel = 4'h3;
    pair_addr = 8'hFE;
    @(negedge sys_clk);
    chk(index_addr_q, 8'h01, "index wrap");
    chk(short_ea_q, 16'h0F80, "short -128");
    chk(long_ea_q, 16'h2FFF, "long 8191");
    chk(rel_target_q, 16'h0080, "rel -128");
    chk(direct_ok_q, 1'b1, "direct 8191");
    chk(wpair_ok_q, 1'b0, "odd wpair");
    chk(rpair_ok_q, 1'b1, "even pair");
    base_reg = 8'h20;
    wreg_data = 8'h10;
    pair_ptr = 16'hF000;
    disp_short = 8'h7F;
    direct_addr = 16'h2000;
    pair_sel = 4'hE;
    pair_addr = 8'hFF;
    @(negedge sys_clk);
    chk(index_addr_q, 8'h30, "index");
    chk(short_ea_q, 16'hF07F, "short +127");
    chk(long_ea_q, 16'h0FFF, "long wrap");
    chk(rel_target_q, 16'h017F, "rel +127");
    chk(direct_ok_q, 1'b0, "direct 8192");
    chk(wpair_ok_q, 1'b1, "even wpair");
    chk(rpair_ok_q, 1'b0, "odd pair");
    $display("test address arithmetic done");
    // status register access, carry ops and write priority
    reg_acc(1'b1, STATUS_ADDR, 8'h80);
    chk(cpu_status_flags_q, 8'h80, "status write");
    reg_acc(1'b0, STATUS_ADDR, 8'h00);
    chk(reg_rdata_q, 8'h80, "status read");
    chk(status_hit_q, 1'b1, "status hit");
    reg_acc(1'b1, 8'hD4, 8'hFF);
    chk(cpu_status_flags_q, 8'h80, "other address");
    reg_acc(1'b0, 8'hD6, 8'h00);
    chk(reg_rdata_q, 8'h00, "other read");
    chk(status_hit_q, 1'b0, "no hit");
    dec(8'hCF);
    @(negedge sys_clk);
    chk(cpu_status_flags_q, 8'h00, "carry clear");
    chk(op_q, OP_CARRY_CLEAR, "carry clear op");
    dec(8'hDF);
    @(negedge sys_clk);
    chk(cpu_status_flags_q, 8'h80, "carry set");
    chk(op_q, OP_CARRY_SET, "carry set op");
    dec(8'hEF);
    @(negedge sys_clk);
    chk(cpu_status_flags_q, 8'h00, "carry complement");
    chk(op_q, OP_CARRY_COMPL, "carry complement op");
    @(negedge sys_clk);
    alu_flag_wr = 1'b1;
    alu_flags = 8'h50;
    @(negedge sys_clk);
    chk(cpu_status_flags_q, 8'h50, "alu update");
    reg_acc(1'b1, STATUS_ADDR, 8'h0F);
    alu_flag_wr = 1'b0;
    chk(cpu_status_flags_q, 8'h0F, "write beats alu");
    $display("test status register done");
    stop_test();
  end
endmodule
